// ==== hw/error_event_status_defs.svh ====
// Purpose: constants for the error event status block
// Assumes: 16-bit configuration register space, byte offsets
// Notes: definitions only
`ifndef ERROR_EVENT_STATUS_DEFS_SVH
`define ERROR_EVENT_STATUS_DEFS_SVH
`define EES_OFFSET 8'hc8
`define EES_RESET 16'h0000
`define EES_BIT_SW_SMI 12
`define EES_BIT_THERM 11
`define EES_BIT_LOCK 9
`define EES_BIT_THROT 7
`define EES_WMASK 16'h1a80
`define CMD_BIT_SERR_EN 8
`endif

// ==== hw/error_event_status_pkg.sv ====
// Purpose: types shared by the error event status block
// Assumes: nothing
// Notes: four event sources
package error_event_status_pkg;
  typedef logic [15:0] reg16_t;
  typedef enum logic [1:0] {
    ev_sw_smi = 2'h0,
    ev_therm = 2'h1,
    ev_lock = 2'h2,
    ev_throt = 2'h3
  } event_id_t;
endpackage

// ==== hw/error_status_flag_logic.sv ====
// Purpose: error event status register and system error message launch
// Assumes: config writes/reads come as strobes with an 8-bit offset decoded here, byte enables
// Notes: enables come from neighbouring command registers as inputs
// How it works
// RQ1: sixteen-bit status at offset c8, resets to zero.
// RQ2: one system error message per flag rising, when both enables allow; here flags rising in the same cycle share one message.
// RQ3: flags set on their events whether or not reporting is enabled; here the thermal flag sets only with one of its three enables.
// RQ4: writing one clears a flag and re-arms it; zero leaves it.
// RQ5: bit 12 set on graphics software event causing an smi.
// RQ6: bit 11 set only when a thermal trip produced an interrupt.
// RQ7: software maps each trip point to at most one interrupt kind.
// RQ8: no thermal interrupt message while bit 11 stays set.
// RQ9: bit 9 set on locked access missing dram.
// RQ10: bit 7 set on dram throttling, zero after clear until next.
// RQ11: message needs the flag's own error command enable.
// RQ12: message also needs the global command serr enable.
// RQ13: reserved bits read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "error_event_status_defs.svh"
module error_status_flag_logic
  import error_event_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  // enables from command registers
  input wire logic [15:0] error_report_enables,
  input wire logic [15:0] pci_command_reg,
  input wire logic therm_smi_en,
  input wire logic therm_sci_en,
  // event sources
  input wire logic sw_smi_event,
  input wire logic therm_trip,
  input wire logic lock_miss_event,
  input wire logic throttle_event,
  // hub link messages
  output logic serr_msg,
  output logic therm_smi_msg,
  output logic therm_sci_msg
);
  // =====================================================
  // decode
  function automatic logic hit(input logic [7:0] a);
    hit = (a == `EES_OFFSET);
  endfunction

  // one flag per event source; the decode below assumes exactly these four
  localparam int NFLAG = 4;
  flag_if #(.N(NFLAG)) fl ();
  logic [15:0] wmask;
  logic therm_serr_en;
  logic therm_fire;
  logic sw_smi_flag, thermal_trip_flag, lock_non_memory_flag, throttle_event_flag;
  reg16_t status;

  sticky_flags #(.N(NFLAG)) u_flags (
    .clk(clk),
    .rstn(rstn),
    .f(fl)
  );

  // =====================================================
  // flags and clears
  // byte-lane mask of write-one-to-clear bits
  assign wmask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} & `EES_WMASK; // RQ13
  assign therm_serr_en = error_report_enables[`EES_BIT_THERM];
  // trade-off: a second trip point sharing the flag is lost until software clears it
  // trip fires a message only while the flag is clear, else it is dropped
  assign therm_fire = therm_trip & ~thermal_trip_flag & (therm_smi_en | therm_sci_en | therm_serr_en); // RQ8 RQ6

  // event sets, independent of reporting enables except the thermal set, which needs one of its three enables
  assign fl.set[ev_sw_smi] = sw_smi_event; // RQ5 RQ3
  assign fl.set[ev_therm] = therm_fire; // RQ6
  assign fl.set[ev_lock] = lock_miss_event; // RQ9 RQ3
  assign fl.set[ev_throt] = throttle_event; // RQ10 RQ3

  // write ones clear
  assign fl.clr[ev_sw_smi] = cfg_wr & hit(cfg_addr) & wmask[`EES_BIT_SW_SMI] & cfg_wdata[`EES_BIT_SW_SMI]; // RQ4
  assign fl.clr[ev_therm] = cfg_wr & hit(cfg_addr) & wmask[`EES_BIT_THERM] & cfg_wdata[`EES_BIT_THERM]; // RQ4
  assign fl.clr[ev_lock] = cfg_wr & hit(cfg_addr) & wmask[`EES_BIT_LOCK] & cfg_wdata[`EES_BIT_LOCK]; // RQ4
  assign fl.clr[ev_throt] = cfg_wr & hit(cfg_addr) & wmask[`EES_BIT_THROT] & cfg_wdata[`EES_BIT_THROT]; // RQ4

  assign sw_smi_flag = fl.state[ev_sw_smi];
  assign thermal_trip_flag = fl.state[ev_therm];
  assign lock_non_memory_flag = fl.state[ev_lock];
  assign throttle_event_flag = fl.state[ev_throt];

  // register image, reserved bits zero
  always_comb begin
    status = `EES_RESET; // RQ1 RQ13
    status[`EES_BIT_SW_SMI] = sw_smi_flag;
    status[`EES_BIT_THERM] = thermal_trip_flag;
    status[`EES_BIT_LOCK] = lock_non_memory_flag;
    status[`EES_BIT_THROT] = throttle_event_flag;
  end

  // =====================================================
  // read data, registered; other offsets answer zero
  // the image is taken before this edge's sets land, so a read never sees half an update
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= `EES_RESET;
    end else if (cfg_rd) begin
      cfg_rdata <= hit(cfg_addr) ? status : 16'h0000; // RQ1
    end
  end

  // =====================================================
  // an event on a flag already set stays silent until software clears it
  // one system error message per cycle in which any enabled flag rises, gated by both enables
  logic serr_go;
  assign serr_go = pci_command_reg[`CMD_BIT_SERR_EN] &
    (|{fl.rise[ev_sw_smi] & error_report_enables[`EES_BIT_SW_SMI],
       fl.rise[ev_therm] & therm_serr_en,
       fl.rise[ev_lock] & error_report_enables[`EES_BIT_LOCK],
       fl.rise[ev_throt] & error_report_enables[`EES_BIT_THROT]}); // RQ2 RQ11 RQ12

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serr_msg <= 1'b0;
    end else begin
      serr_msg <= serr_go; // RQ2
    end
  end

  // nothing here guards a doubly mapped trip: both messages would go out
  // thermal smi/sci messages; software keeps one kind per trip point
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      therm_smi_msg <= 1'b0;
      therm_sci_msg <= 1'b0;
    end else begin
      therm_smi_msg <= therm_fire & therm_smi_en; // RQ8 RQ7
      therm_sci_msg <= therm_fire & therm_sci_en; // RQ8 RQ7
    end
  end

  // =====================================================
  // checks
  // flags set on their events and stay until written
  flag_sets_a: assert property (@(posedge clk) disable iff (!rstn) // RQ9
    lock_miss_event |=> lock_non_memory_flag)
    else $error("lock flag did not set");
  throt_sets_a: assert property (@(posedge clk) disable iff (!rstn) // RQ10
    throttle_event |=> throttle_event_flag)
    else $error("throttle flag did not set");
  swsmi_sets_a: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    sw_smi_event |=> sw_smi_flag)
    else $error("software smi flag did not set");
  lock_keeps_a: assert property (@(posedge clk) disable iff (!rstn) // RQ4 RQ3
    (lock_non_memory_flag && !(cfg_wr && hit(cfg_addr))) |=> lock_non_memory_flag)
    else $error("lock flag dropped without a write");

  // write one clears, write zero keeps
  clear_works_a: assert property (@(posedge clk) disable iff (!rstn) // RQ4
    (fl.clr[ev_lock] && !lock_miss_event) |=> !lock_non_memory_flag)
    else $error("write one did not clear");
  zero_keeps_a: assert property (@(posedge clk) disable iff (!rstn) // RQ4
    (cfg_wr && hit(cfg_addr) && !cfg_wdata[`EES_BIT_THROT] && throttle_event_flag) |=> throttle_event_flag)
    else $error("write zero cleared a flag");
  throt_clears_a: assert property (@(posedge clk) disable iff (!rstn) // RQ10 RQ4
    (cfg_wr && hit(cfg_addr) && cfg_be[0] && cfg_wdata[`EES_BIT_THROT] && !throttle_event) |=> !throttle_event_flag)
    else $error("throttle flag did not clear");
  therm_clears_a: assert property (@(posedge clk) disable iff (!rstn) // RQ4
    (cfg_wr && hit(cfg_addr) && cfg_be[1] && cfg_wdata[`EES_BIT_THERM] && !therm_trip) |=> !thermal_trip_flag)
    else $error("thermal flag did not clear");
  swsmi_clears_a: assert property (@(posedge clk) disable iff (!rstn) // RQ5 RQ4
    (cfg_wr && hit(cfg_addr) && cfg_be[1] && cfg_wdata[`EES_BIT_SW_SMI] && !sw_smi_event) |=> !sw_smi_flag)
    else $error("software smi flag did not clear");

  // read port
  reserved_a: assert property (@(posedge clk) disable iff (!rstn) // RQ13
    (cfg_rdata & ~`EES_WMASK) == 16'h0000)
    else $error("reserved bit reads one");
  rd_other_a: assert property (@(posedge clk) disable iff (!rstn) // RQ1
    cfg_rd && !hit(cfg_addr) |=> cfg_rdata == '0)
    else $error("other offset read not zero");
  rd_hold_a: assert property (@(posedge clk) disable iff (!rstn) // RQ1
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved without a read");
  rd_lock_a: assert property (@(posedge clk) disable iff (!rstn) // RQ9 RQ1
    cfg_rd && hit(cfg_addr) |=> cfg_rdata[`EES_BIT_LOCK] == $past(lock_non_memory_flag))
    else $error("lock flag read wrong");

  // system error messages
  serr_gate_a: assert property (@(posedge clk) disable iff (!rstn) // RQ12
    serr_msg |-> $past(pci_command_reg[`CMD_BIT_SERR_EN]))
    else $error("serr without global enable");
  serr_once_a: assert property (@(posedge clk) disable iff (!rstn) // RQ2 RQ11
    (lock_miss_event && !lock_non_memory_flag && error_report_enables[`EES_BIT_LOCK]
     && pci_command_reg[`CMD_BIT_SERR_EN]) |=> serr_msg)
    else $error("missing serr message");
  serr_enable_a: assert property (@(posedge clk) disable iff (!rstn) // RQ11
    serr_msg |-> ($past(error_report_enables) & `EES_WMASK) != '0)
    else $error("serr without any flag enable");
  serr_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // RQ2
    (lock_non_memory_flag && !sw_smi_event && !therm_trip && !throttle_event) |=> !serr_msg)
    else $error("serr without a rising flag");

  // thermal path
  therm_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // RQ8
    thermal_trip_flag |=> !$rose(therm_smi_msg) || !$past(thermal_trip_flag, 1))
    else $error("thermal message while flag set");
  therm_cause_a: assert property (@(posedge clk) disable iff (!rstn) // RQ6
    $rose(thermal_trip_flag) |-> $past(therm_trip) && $past(therm_smi_en | therm_sci_en | therm_serr_en))
    else $error("thermal flag without a message");
  therm_sets_a: assert property (@(posedge clk) disable iff (!rstn) // RQ6 RQ3
    (therm_trip && !thermal_trip_flag && (therm_smi_en || therm_sci_en || therm_serr_en)) |=> thermal_trip_flag)
    else $error("thermal flag did not set");
  therm_idle_a: assert property (@(posedge clk) disable iff (!rstn) // RQ6
    (!therm_trip && !thermal_trip_flag) |=> !thermal_trip_flag)
    else $error("thermal flag set without a trip");
  therm_lost_a: assert property (@(posedge clk) disable iff (!rstn) // RQ8
    (therm_trip && thermal_trip_flag) |=> !therm_smi_msg && !therm_sci_msg)
    else $error("thermal message for a masked trip");
  smi_gate_a: assert property (@(posedge clk) disable iff (!rstn) // RQ6 RQ7
    therm_smi_msg |-> $past(therm_smi_en))
    else $error("thermal smi without its enable");
  sci_gate_a: assert property (@(posedge clk) disable iff (!rstn) // RQ6 RQ7
    therm_sci_msg |-> $past(therm_sci_en))
    else $error("thermal sci without its enable");
endmodule
`default_nettype wire

// ==== hw/flag_if.sv ====
// Purpose: carries flag set, clear and state between the status modules
// Assumes: one clock
// Notes: width is a parameter
`timescale 1ns/10ps
`default_nettype none
interface flag_if #(parameter int N = 4);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] state;
  logic [N-1:0] rise;
  modport owner (input set, input clr, output state, output rise);
  modport user (output set, output clr, input state, input rise);
endinterface
`default_nettype wire

// ==== hw/sticky_flags.sv ====
// Purpose: bank of sticky event flags with write-one-to-clear
// Assumes: set and clear arrive as single-cycle levels
// Notes: set wins over clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module sticky_flags #(
  parameter int N = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // flag traffic
  flag_if.owner f
);
  // refuse an empty bank while elaborating
  if (N < 1) begin : g_bad_n
    $error("sticky_flags needs at least one flag");
  end
  // =====================================================
  // flag storage
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      logic flag_r;
      // set beats clear so no event is lost
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          flag_r <= 1'b0;
        end else if (f.set[i]) begin
          flag_r <= 1'b1;
        end else if (f.clr[i]) begin
          flag_r <= 1'b0;
        end
      end
      assign f.state[i] = flag_r;
      assign f.rise[i] = f.set[i] & ~flag_r; // 0-to-1 edge
    end
  endgenerate
endmodule
`default_nettype wire

// ==== test/hub_sink.sv ====
// Purpose: hub side sink that tallies messages from the status block
// Assumes: every message is a one-cycle pulse
// Notes: a pulse held two cycles would count twice
`timescale 1ns/10ps
`default_nettype none
module hub_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // messages from the status block
  input wire logic serr_msg,
  input wire logic therm_smi_msg,
  input wire logic therm_sci_msg,
  // tallies for the bench
  output var int serr_seen,
  output var int therm_seen
);
  // ==========
  // tally
  // one message per pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serr_seen <= 0;
      therm_seen <= 0;
    end else begin
      serr_seen <= serr_seen + int'(serr_msg);
      therm_seen <= therm_seen + int'(therm_smi_msg) + int'(therm_sci_msg);
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: random self-checking bench for the error event status block
// Assumes: inputs change at rising edges, outputs read at falling edges
// Notes: reads only on quiet cycles, so read data never races an update
`timescale 1ns/10ps
`default_nettype none
`include "error_event_status_defs.svh"
module tb_top
  import error_event_status_pkg::*;
;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, smi = 0, sci = 0;
  logic sw = 0, th = 0, lk = 0, thr = 0, serr, tsmi, tsci, acc, rd_n;
  logic [7:0] addr = 8'h00;
  logic [1:0] be = 2'h0, m;
  reg16_t wd = '0, ere = '0, pci = '0, rdata;
  logic [15:0] flg = 16'h0000, rd_e = 16'h0000, setv, clrm, lf = 16'heda0, a, b;
  logic serr_e = 0, smi_e = 0, sci_e = 0;
  int fail_count = 0, n_compared = 0, cyc = 0, n_serr = 0, n_th = 0, serr_seen, therm_seen;
  error_status_flag_logic dut_u (.clk(clk), .rstn(rstn), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr),
    .cfg_be(be), .cfg_wdata(wd), .cfg_rdata(rdata), .error_report_enables(ere), .pci_command_reg(pci),
    .therm_smi_en(smi), .therm_sci_en(sci), .sw_smi_event(sw), .therm_trip(th), .lock_miss_event(lk),
    .throttle_event(thr), .serr_msg(serr), .therm_smi_msg(tsmi), .therm_sci_msg(tsci));
  hub_sink hub_u (.clk(clk), .rstn(rstn), .serr_msg(serr), .therm_smi_msg(tsmi), .therm_sci_msg(tsci),
    .serr_seen(serr_seen), .therm_seen(therm_seen));
  // ==========
  // clock and hang guard
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ceiling well above the 3021 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      conclude();
    end
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction
  task automatic check16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========
  // main sequence: model takes the inputs sampled at each edge
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      acc = th && !flg[`EES_BIT_THERM] && (smi || sci || ere[`EES_BIT_THERM]);
      setv = {3'h0, sw, acc, 1'b0, lk, 1'b0, thr, 7'h00};
      clrm = (wr && addr == `EES_OFFSET) ? wd & {{8{be[1]}}, {8{be[0]}}} & `EES_WMASK : 16'h0000;
      serr_e = (|(setv & ~flg & ere)) && pci[`CMD_BIT_SERR_EN];
      smi_e = acc && smi;
      sci_e = acc && sci;
      if (rd) rd_e = (addr == `EES_OFFSET) ? flg : 16'h0000;
      flg = (flg & ~clrm) | setv; // set wins over a clear in the same cycle
      n_serr += int'(serr_e);
      n_th += int'(smi_e) + int'(sci_e);
      lf = lfsr_next(lf);
      a = lf;
      lf = lfsr_next(lf);
      b = lf;
      rd_n = a[1:0] == 2'h0;
      rd <= rd_n;
      wr <= !rd_n && a[4:2] == 3'h0;
      sw <= !rd_n && a[7:5] == 3'h0;
      th <= !rd_n && a[10:8] == 3'h0;
      lk <= !rd_n && a[13:11] == 3'h0;
      thr <= !rd_n && b[2:0] == 3'h0;
      addr <= (b[5:3] == 3'h0) ? 8'hca : `EES_OFFSET;
      be <= b[7:6];
      wd <= {a[15:8], b[15:8]};
      // enables move now and then; one thermal action at most
      if (i % 50 == 0) begin
        m = b[9:8];
        smi <= m == 2'h1;
        sci <= m == 2'h2;
        ere <= (a & 16'hf7ff) | ((m == 2'h3) ? 16'h0800 : 16'h0000);
        pci <= {b[15:9], a[14], b[7:0]};
      end
      @(negedge clk);
      check16("cfg_rdata", rd_e, rdata);
      check1("serr_msg", serr_e, serr);
      check1("therm_smi_msg", smi_e, tsmi);
      check1("therm_sci_msg", sci_e, tsci);
    end
    // the hub tallies a pulse one edge after it launches
    @(posedge clk);
    @(negedge clk);
    check16("serr count", n_serr[15:0], serr_seen[15:0]);
    check16("thermal count", n_th[15:0], therm_seen[15:0]);
    conclude();
  end
endmodule
`default_nettype wire
